//--- frame_trigger_sequencer.sv
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "trig_defs.svh"

module frame_trigger_sequencer
  import trig_pkg::*;
#(
  parameter int DW = 32
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          external_frame_trigger_in,
  output logic               exposure_active,
  output logic               frame_start,
  output logic               overtrigger
);
  // ****************************************
  // Registers
  // ****************************************
  logic [`CTRL_W-1:0] ctrl_q;
  logic [DW-1:0]      trigger_holdoff_us;
  logic [DW-1:0]      frame_rate_setting;
  logic [DW-1:0]      min_period_q;
  logic [DW-1:0]      exposure_duration_setting;
  logic [15:0]        over_cnt_q;
  logic               ack_q;
  logic [31:0]        rdata_q;

  logic trigger_on_off_select;
  logic capture_mode_select;
  logic frame_rate_limit_enable;
  logic fs_trig_on;
  logic trigger_origin_select;
  logic trigger_edge_select;
  logic exposure_control_select;
  assign trigger_on_off_select   = ctrl_q[`CTRL_ACQ_TRIG];
  assign capture_mode_select     = ctrl_q[`CTRL_CONT];
  assign frame_rate_limit_enable = ctrl_q[`CTRL_RATE_EN];
  assign fs_trig_on              = ctrl_q[`CTRL_FS_TRIG];
  assign trigger_origin_select   = ctrl_q[`CTRL_FS_SW];
  assign trigger_edge_select     = ctrl_q[`CTRL_FALLING];
  assign exposure_control_select = ctrl_q[`CTRL_WIDTH_EXP];

  // ****************************************
  // Bus decode
  // ****************************************
  // One wait cycle per access keeps read data registered
  wire acc      = (avs_read || avs_write) && !ack_q;
  wire wr_fire  = avs_write && ack_q;
  wire sel_ctrl = (avs_address == `OFF_CTRL);
  wire sel_cmd  = (avs_address == `OFF_CMD);
  wire sel_hold = (avs_address == `OFF_HOLDOFF);
  wire sel_per  = (avs_address == `OFF_PERIOD);
  wire sel_min  = (avs_address == `OFF_MINPER);
  wire sel_exp  = (avs_address == `OFF_EXPOSURE);
  wire cmd_start = wr_fire && sel_cmd && avs_byteenable[0] && avs_writedata[`CMD_START];
  wire cmd_stop  = wr_fire && sel_cmd && avs_byteenable[0] && avs_writedata[`CMD_STOP];
  wire cmd_sw    = wr_fire && sel_cmd && avs_byteenable[0] && avs_writedata[`CMD_SWTRIG];

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata    = rdata_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Sequencer state
  // ****************************************
  acq_state_t    st_q;
  logic          armed_q;
  logic          single_done_q;
  logic [DW-1:0] delay_q;
  logic          delay_run_q;
  logic [DW-1:0] per_q;
  logic [DW-1:0] exp_q;
  logic [3:0]    tick_q;
  logic [3:0]    exp_sub_q;
  logic          tick;
  logic          width_mode_q;

  logic line_rise;
  logic line_fall;

  edge_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (external_frame_trigger_in),
    .level    (),
    .rise     (line_rise),
    .fall     (line_fall)
  );

  wire [31:0] status_word = {28'h0, exposure_active, armed_q,
                             st_q == ST_WAIT, ctrl_q[`CTRL_LEGACY]};

  wire hw_edge  = trigger_edge_select ? line_fall : line_rise;
  wire hw_end   = trigger_edge_select ? line_rise : line_fall;
  // Acquisition trigger behaves as the frame start trigger
  wire ext_mode = trigger_on_off_select || fs_trig_on;
  wire use_delay = ext_mode && !trigger_origin_select
                   && (trigger_holdoff_us != '0);
  wire ext_req  = ext_mode && (trigger_origin_select ? cmd_sw : hw_edge);
  // Fires on the tick after the count reaches zero, so the holdoff is never shorter than set
  wire delay_done = delay_run_q && tick && (delay_q == '0);
  wire ext_fire = use_delay ? delay_done : (ext_req && !delay_run_q);
  // Period never shorter than the allowed minimum
  wire [DW-1:0] eff_period = (frame_rate_limit_enable && frame_rate_setting > min_period_q)
                             ? frame_rate_setting : min_period_q;
  wire int_fire = !ext_mode && armed_q && (per_q == '0)
                  && !(single_done_q && !capture_mode_select);
  // Rate limit only feeds the internal generator; line edges pace frames directly
  wire trig     = ext_mode ? ext_fire : int_fire;
  wire take     = trig && (st_q == ST_WAIT);
  // The internal generator waits out an exposure, so only outside triggers overrun
  wire over_ev  = ext_mode && ext_fire && (st_q == ST_EXPOSE);

  assign tick = (tick_q == 4'(`TICK_CYCLES - 1));
  // Exposure has its own prescaler, restarted at the trigger, so a timed
  // exposure is not cut short by the phase of the shared tick
  wire exp_tick = (exp_sub_q == 4'(`TICK_CYCLES - 1));

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q                    <= `CTRL_RESET;
      trigger_holdoff_us        <= `HOLDOFF_RESET;
      frame_rate_setting        <= `PERIOD_RESET;
      min_period_q              <= `MINPER_RESET;
      exposure_duration_setting <= `EXPOSURE_RESET;
      ack_q                     <= 1'b0;
      rdata_q                   <= 32'h0;
    end else begin
      ack_q <= acc;
      if (wr_fire && sel_ctrl && avs_byteenable[0]) begin
        ctrl_q <= avs_writedata[`CTRL_W-1:0];
      end
      if (wr_fire && sel_hold) begin
        trigger_holdoff_us <= merge(trigger_holdoff_us, avs_writedata, avs_byteenable);
      end
      if (wr_fire && sel_per) begin
        frame_rate_setting <= merge(frame_rate_setting, avs_writedata, avs_byteenable);
      end
      if (wr_fire && sel_min) begin
        min_period_q <= merge(min_period_q, avs_writedata, avs_byteenable);
      end
      if (wr_fire && sel_exp) begin
        exposure_duration_setting <= merge(exposure_duration_setting, avs_writedata,
                                           avs_byteenable);
      end
      if (acc && avs_read) begin
        if (sel_ctrl) begin
          rdata_q <= {24'h0, ctrl_q};
        end else if (sel_hold) begin
          rdata_q <= trigger_holdoff_us;
        end else if (sel_per) begin
          rdata_q <= frame_rate_setting;
        end else if (sel_min) begin
          rdata_q <= min_period_q;
        end else if (sel_exp) begin
          rdata_q <= exposure_duration_setting;
        end else if (avs_address == `OFF_STATUS) begin
          rdata_q <= status_word;
        end else if (avs_address == `OFF_OVERCNT) begin
          rdata_q <= {16'h0, over_cnt_q};
        end else begin
          rdata_q <= 32'h0;
        end
      end
    end
  end

  // ****************************************
  // Microsecond tick and holdoff counter
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q      <= 4'h0;
      delay_q     <= '0;
      delay_run_q <= 1'b0;
    end else begin
      tick_q <= tick ? 4'h0 : tick_q + 4'h1;
      if (!use_delay || cmd_stop) begin
        delay_run_q <= 1'b0;
      end else if (ext_req && !delay_run_q) begin
        // Edges during a running holdoff are not queued
        delay_q     <= trigger_holdoff_us;
        delay_run_q <= 1'b1;
      end else if (delay_run_q && tick) begin
        if (delay_done) begin
          delay_run_q <= 1'b0;
        end else begin
          delay_q <= delay_q - 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Acquisition state and internal generator
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= ST_IDLE;
      armed_q       <= 1'b0;
      single_done_q <= 1'b0;
      per_q         <= '0;
      exp_q         <= '0;
      exp_sub_q     <= 4'h0;
      width_mode_q  <= 1'b0;
      over_cnt_q    <= 16'h0;
    end else begin
      if (over_ev) begin
        over_cnt_q <= over_cnt_q + 16'h1;
      end
      exp_sub_q <= exp_tick ? 4'h0 : exp_sub_q + 4'h1;
      if (tick && per_q != '0) begin
        per_q <= per_q - 1'b1;
      end
      if (take && !ext_mode) begin
        per_q         <= eff_period;
        single_done_q <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (cmd_start) begin
            st_q          <= ST_WAIT;
            armed_q       <= 1'b1;
            single_done_q <= 1'b0;
            per_q         <= '0;
          end
        end
        ST_WAIT: begin
          if (cmd_stop || (!ext_mode && !capture_mode_select && single_done_q)) begin
            st_q    <= ST_IDLE;
            armed_q <= 1'b0;
          end else if (take) begin
            st_q <= ST_EXPOSE;
            // Width exposure only for hardware line triggers
            width_mode_q <= exposure_control_select && ext_mode && !trigger_origin_select;
            exp_q        <= exposure_duration_setting;
            exp_sub_q    <= 4'h0;
          end
        end
        ST_EXPOSE: begin
          if (width_mode_q) begin
            if (hw_end || cmd_stop) begin
              st_q <= cmd_stop ? ST_IDLE : ST_WAIT;
            end
          end else if (exp_tick) begin
            if (exp_q <= {{(DW-1){1'b0}}, 1'b1}) begin
              st_q <= ST_WAIT;
            end else begin
              exp_q <= exp_q - 1'b1;
            end
          end
          if (cmd_stop) begin
            armed_q <= 1'b0;
            st_q    <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic fs_q;
  logic ov_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      fs_q <= take && !(st_q == ST_WAIT && cmd_stop);
      ov_q <= over_ev;
    end
  end

  assign frame_start     = fs_q;
  assign overtrigger     = ov_q;
  assign exposure_active = (st_q == ST_EXPOSE);
endmodule // frame_trigger_sequencer

//--- trig_defs.svh
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFF_CTRL      8'h00
`define OFF_CMD       8'h04
`define OFF_HOLDOFF   8'h08
`define OFF_PERIOD    8'h0c
`define OFF_MINPER    8'h10
`define OFF_EXPOSURE  8'h14
`define OFF_STATUS    8'h18
`define OFF_OVERCNT   8'h1c

// ****************************************
// Control field positions
// ****************************************
`define CTRL_LEGACY     0
`define CTRL_ACQ_TRIG   1
`define CTRL_CONT       2
`define CTRL_RATE_EN    3
`define CTRL_FS_TRIG    4
`define CTRL_FS_SW      5
`define CTRL_FALLING    6
`define CTRL_WIDTH_EXP  7
`define CTRL_W          8

// ****************************************
// Command bits
// ****************************************
`define CMD_START  0
`define CMD_STOP   1
`define CMD_SWTRIG 2

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET      8'h01
`define HOLDOFF_RESET   32'h0000_0000
`define PERIOD_RESET    32'h0000_0000
`define MINPER_RESET    32'h0000_0064
`define EXPOSURE_RESET  32'h0000_0064

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ       10
`define US_NS         1000
`define CLK_NS        100
`define TICK_CYCLES   (`US_NS / `CLK_NS)

`endif

//--- trig_pkg.sv
package trig_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXPOSE
  } acq_state_t;
endpackage

//--- edge_sync.sv
`timescale 1ns/1ps
`include "trig_defs.svh"

// Three-stage pin synchroniser; an edge counts once stages two and three agree.
module edge_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level = lvl_q;
  assign rise  = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall  = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // edge_sync

//--- trig_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port-level checks of the sequencer
// ****************************************
module trig_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        external_frame_trigger_in,
  input wire logic        exposure_active,
  input wire logic        frame_start,
  input wire logic        overtrigger
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request not stalled");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  chk_data_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h1c
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_cmd_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h04
    |=> avs_readdata == 32'h0) else $error("command read not zero");
  chk_start_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  chk_start_expose: assert property (frame_start |-> ##[0:1] exposure_active)
    else $error("frame start without exposure");
  chk_over_pulse: assert property (overtrigger |=> !overtrigger)
    else $error("overtrigger longer than one cycle");
  chk_over_busy: assert property (overtrigger |-> $past(exposure_active))
    else $error("overtrigger outside exposure");
endmodule // trig_monitor

bind frame_trigger_sequencer trig_monitor trig_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .external_frame_trigger_in(external_frame_trigger_in),
  .exposure_active(exposure_active), .frame_start(frame_start), .overtrigger(overtrigger));

//--- pin_driver.sv
`timescale 1ns/1ps
// ****************************************
// External trigger source, idle low
// ****************************************
module pin_driver (
  input wire logic        core_clk,
  input wire logic        fire,
  input wire logic [15:0] width,
  output logic            pin
);
  logic [15:0] left_q = 16'h0;
  // Pulse high for width cycles; rising edge is the active edge unless CTRL_FALLING is set
  always @(posedge core_clk) begin
    if (fire) begin
      left_q <= width;
    end else if (left_q != 16'h0) begin
      left_q <= left_q - 16'h1;
    end
  end
  assign pin = (left_q != 16'h0);
endmodule // pin_driver

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, fire = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [15:0] pw = 16'h1;
  logic        wreq, pin, expo, fs, ovt;
  int fails = 0, compares = 0, c, ks, ko;
  frame_trigger_sequencer frame_trigger_sequencer_i (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .external_frame_trigger_in(pin), .exposure_active(expo), .frame_start(fs),
    .overtrigger(ovt));
  pin_driver pin_driver_i (.core_clk(core_clk), .fire(fire), .width(pw), .pin(pin));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic chk_eq(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) begin
      fails++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (fs !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic count_ev(input int cyc, output int s, output int o, output int e);
    s = 0;
    o = 0;
    e = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      s += (fs === 1'b1);
      o += (ovt === 1'b1);
      e += (expo === 1'b1);
    end
  endtask
  task automatic pulse(input logic [15:0] w);
    pw <= w;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 8'h00, 32'h0);
    chk_eq(q, 32'h1);
    bus(1'b0, 8'h18, 32'h0);
    chk_eq(q, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    chk_eq(q, 32'h64);
    bus(1'b0, 8'h40, 32'h0);
    chk_eq(q, 32'h0);
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b0, 8'h14, 32'h0);
    chk_eq(q, 32'h3);
    bus(1'b1, 8'h10, 32'h5);
    bus(1'b1, 8'h04, 32'h1);
    count_ev(400, ks, ko, c);
    chk_eq(ks, 1);
    chk_rng(c, 29, 31);
    bus(1'b1, 8'h00, 32'h5);
    bus(1'b1, 8'h04, 32'h1);
    wait_start(c);
    wait_start(c);
    chk_rng(c, 49, 51);
    bus(1'b1, 8'h0c, 32'h9);
    bus(1'b1, 8'h00, 32'hd);
    wait_start(c);
    wait_start(c);
    chk_rng(c, 89, 91);
    bus(1'b1, 8'h0c, 32'h2);
    wait_start(c);
    wait_start(c);
    chk_rng(c, 49, 51);
    bus(1'b1, 8'h04, 32'h2);
    count_ev(200, ks, ko, c);
    chk_eq(ks, 0);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h00, 32'h15);
    bus(1'b1, 8'h04, 32'h1);
    pulse(16'h14);
    wait_start(c);
    chk_rng(c, 32, 46);
    bus(1'b1, 8'h08, 32'h0);
    repeat (60) @(posedge core_clk);
    pulse(16'h5);
    wait_start(c);
    chk_rng(c, 2, 7);
    // A one-cycle low gap is filtered by the synchroniser, so let the line settle
    repeat (5) @(posedge core_clk);
    pulse(16'h5);
    count_ev(25, ks, ko, c);
    chk_eq(ks, 0);
    chk_eq(ko, 1);
    repeat (40) @(posedge core_clk);
    pulse(16'h5);
    wait_start(c);
    // Second line edge 80 cycles after the first; frame spacing must follow it
    repeat (74) @(posedge core_clk);
    pulse(16'h5);
    wait_start(c);
    chk_rng(c + 75, 79, 83);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h00, 32'h35);
    repeat (50) @(posedge core_clk);
    bus(1'b1, 8'h04, 32'h4);
    // The start pulse is over before the write returns; exposure shows the trigger
    count_ev(20, ks, ko, c);
    chk_eq(c, 20);
    repeat (50) @(posedge core_clk);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'h95);
    pulse(16'h3c);
    count_ev(150, ks, ko, c);
    chk_rng(c, 58, 62);
    bus(1'b1, 8'h00, 32'h55);
    pulse(16'h5);
    wait_start(c);
    chk_rng(c, 9, 11);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk_eq(q, 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    chk_eq(q, 32'h1);
    give_verdict();
  end
endmodule // tb_top
